//--- verilog/pgs_params.svh
// Timing constants and reset values for the power GPIO sequencer
`ifndef PGS_PARAMS_SVH
`define PGS_PARAMS_SVH

// Clock period of the sequencer clock, in ns
`define PGS_CLK_PERIOD_NS  100
// Longest time allowed between the two edges of a sequenced step, in ns
`define PGS_GAP_MAX_NS     12500
// Longest time rounds down to whole cycles
`define PGS_GAP_CYCLES     (`PGS_GAP_MAX_NS / `PGS_CLK_PERIOD_NS)
// Default number of current-setting profiles
`define PGS_NUM_PROFILES   4
// Reset level of every power control output
`define PGS_OUT_RESET      1'b0

`endif

//--- verilog/pgs_pkg.sv
// Types shared by the power GPIO sequencer
package pgs_pkg;

  typedef enum logic [1:0] {
    LVL_5V  = 2'b00,
    LVL_9V  = 2'b01,
    LVL_20V = 2'b10
  } pgs_level_t;

  typedef enum logic [2:0] {
    ST_UNATT   = 3'b000,
    ST_SRC_ATT = 3'b001,
    ST_SRC_RUN = 3'b010,
    ST_SRC_GAP = 3'b011,
    ST_SNK_ATT = 3'b100,
    ST_SNK_GAP = 3'b101,
    ST_SNK_RUN = 3'b110
  } pgs_state_t;

endpackage : pgs_pkg

//--- verilog/pgs_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pgs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pgs_sync

//--- verilog/pgs_sequencer.sv
// Type-C attach and PD power GPIO sequencer, sink and source roles
//
// What this block does
// - As a sink, the current-setting output for the negotiated profile rises before load enable.
// - Load enable rises no more than 12.5 us after the current-setting output rose.
// - As a source, 5 V is given first and a higher level only when the profile allows it.
// - The source level is chosen by pins: one supply enable for 5 V, one select per higher level.
// - Supply enable is high at 5, 9 and 20 V; the 9 V and 20 V selects are high only at their level.
// - Going from 5 V to a higher level only raises one select, with no ordering constraint.
// - Between two higher levels the old select drops first and the new one rises within 12.5 us.
// - Both ports start unattached before any power is applied.
// - The source sees the sink pull-down on CC, attaches, and only then turns on VBUS and VCONN.
`timescale 1ns/1ps
`include "pgs_params.svh"

// Pin senses pass two flops, so attach shows three edges after a pin rises.
// Both sequenced gaps wait the full allowed span; a shorter one would also do,
// but the full span gives external supplies the most time to settle.
// A 9 V to 20 V swap holds both selects low for GAP_CYCLES edges.
// The sink raises load enable GAP_CYCLES edges after the current setting.
// A new source target is not taken during the gap, only back in the run state.
// Detach drops every output in one edge, with no ordering between them.
// Request code 2'b11 is clamped to the allowed level; it becomes 5 V only when the allowed code is 5 V or 2'b11.

module pgs_sequencer #(
  parameter int NUM_PROFILES = `PGS_NUM_PROFILES,
  parameter int GAP_CYCLES   = `PGS_GAP_CYCLES,
  parameter int SEL_W        = (NUM_PROFILES > 1) ? $clog2(NUM_PROFILES) : 1
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    role_source,
  input  wire logic                    cc_rd_detect,
  input  wire logic                    vbus_detect,
  input  wire logic                    profile_valid,
  input  wire logic [SEL_W-1:0]        profile_sel,
  input  wire pgs_pkg::pgs_level_t     request_level,
  input  wire pgs_pkg::pgs_level_t     allowed_level,
  output logic                         attached,
  output logic                         vbus_enable,
  output logic                         vconn_enable,
  output logic                         supply_enable,
  output logic                         nine_volt_select,
  output logic                         twenty_volt_select,
  output logic [NUM_PROFILES-1:0]      current_setting_select,
  output logic                         load_switch_enable
);
  import pgs_pkg::*;

  localparam int GW = $clog2(GAP_CYCLES + 1);
  localparam logic [GW-1:0] GAP_LOAD = GW'(GAP_CYCLES - 1);

  pgs_state_t       state_q;
  pgs_level_t       level_q;
  pgs_level_t       target;
  logic [GW-1:0]    gap_q;
  logic [SEL_W-1:0] sel_q;
  logic             rd_seen;
  logic             vbus_seen;
  logic             detach;
  logic             in_src;
  logic             in_snk;

  // Select pin pattern for a level, as {twenty, nine}
  function automatic logic [1:0] level_selects(input pgs_level_t lvl);
    case (lvl)
      LVL_9V:  level_selects = 2'b01;
      LVL_20V: level_selects = 2'b10;
      default: level_selects = 2'b00;
    endcase
  endfunction : level_selects


  // CC and VBUS sense come from pins
  pgs_sync #(
    .W (2)
  ) u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in ({cc_rd_detect, vbus_detect}),
    .sync_out ({rd_seen, vbus_seen})
  );


  // clamp to profile
  // A request beyond what the contract allows is held at the allowed level.
  always_comb begin
    target = (request_level > allowed_level) ? allowed_level : request_level;
    if (target != LVL_9V && target != LVL_20V) begin
      target = LVL_5V;
    end
  end


  always_comb begin
    in_src = (state_q == ST_SRC_ATT) || (state_q == ST_SRC_RUN) || (state_q == ST_SRC_GAP);
    in_snk = (state_q == ST_SNK_ATT) || (state_q == ST_SNK_GAP) || (state_q == ST_SNK_RUN);
    // Source loses the pull-down or the role; sink loses VBUS or the role
    detach = (in_src && (!rd_seen || !role_source))
          || (in_snk && (!vbus_seen || role_source));
  end


  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q                <= ST_UNATT;
      level_q                <= LVL_5V;
      gap_q                  <= '0;
      sel_q                  <= '0;
      attached               <= `PGS_OUT_RESET;
      vbus_enable            <= `PGS_OUT_RESET;
      vconn_enable           <= `PGS_OUT_RESET;
      supply_enable          <= `PGS_OUT_RESET;
      nine_volt_select       <= `PGS_OUT_RESET;
      twenty_volt_select     <= `PGS_OUT_RESET;
      current_setting_select <= '0;
      load_switch_enable     <= `PGS_OUT_RESET;
    end else if (detach || state_q == ST_UNATT) begin
      // outputs low unattached
      // Power is cut in one cycle; detach needs no ordering.
      attached               <= 1'b0;
      vbus_enable            <= 1'b0;
      vconn_enable           <= 1'b0;
      supply_enable          <= 1'b0;
      nine_volt_select       <= 1'b0;
      twenty_volt_select     <= 1'b0;
      current_setting_select <= '0;
      load_switch_enable     <= 1'b0;
      level_q                <= LVL_5V;
      gap_q                  <= '0;
      state_q                <= ST_UNATT;
      if (!detach) begin
        if (role_source && rd_seen) begin
          attached <= 1'b1;
          state_q  <= ST_SRC_ATT;
        end else if (!role_source && vbus_seen) begin
          attached <= 1'b1;
          state_q  <= ST_SNK_ATT;
        end
      end
    end else begin
      case (state_q)
        ST_SRC_ATT: begin
          vbus_enable   <= 1'b1;
          vconn_enable  <= 1'b1;
          supply_enable <= 1'b1;
          level_q       <= LVL_5V;
          state_q       <= ST_SRC_RUN;
        end
        ST_SRC_RUN: begin
          if (target != level_q) begin
            level_q <= target;
            if (level_q == LVL_5V) begin
              {twenty_volt_select, nine_volt_select} <= level_selects(target);
            end else begin
              nine_volt_select   <= 1'b0;
              twenty_volt_select <= 1'b0;
              if (target != LVL_5V) begin
                gap_q   <= GAP_LOAD;
                state_q <= ST_SRC_GAP;
              end
            end
          end
        end
        ST_SRC_GAP: begin
          if (gap_q == '0) begin
            {twenty_volt_select, nine_volt_select} <= level_selects(level_q);
            state_q <= ST_SRC_RUN;
          end else begin
            gap_q <= gap_q - GW'(1);
          end
        end
        ST_SNK_ATT: begin
          if (profile_valid) begin
            current_setting_select <= NUM_PROFILES'(1) << profile_sel;
            sel_q                  <= profile_sel;
            gap_q                  <= GAP_LOAD;
            state_q                <= ST_SNK_GAP;
          end
        end
        ST_SNK_GAP: begin
          if (!profile_valid || profile_sel != sel_q) begin
            current_setting_select <= '0;
            state_q                <= ST_SNK_ATT;
          end else if (gap_q == '0) begin
            load_switch_enable <= 1'b1;
            state_q            <= ST_SNK_RUN;
          end else begin
            gap_q <= gap_q - GW'(1);
          end
        end
        ST_SNK_RUN: begin
          // Profile lost or changed: remove load before a new setting shows
          if (!profile_valid || profile_sel != sel_q) begin
            load_switch_enable     <= 1'b0;
            current_setting_select <= '0;
            state_q                <= ST_SNK_ATT;
          end
        end
        default: begin
          state_q <= ST_UNATT;
        end
      endcase
    end
  end
endmodule : pgs_sequencer

//--- test/pgs_sequencer_asserts.sv
// Port checks for the power GPIO sequencer
`timescale 1ns/1ps
module pgs_sequencer_asserts #(
  parameter int NUM_PROFILES = 4,
  parameter int GAP_CYCLES   = 125
) (
  input wire logic                    clk,
  input wire logic                    arst_n,
  input wire logic                    role_source,
  input wire pgs_pkg::pgs_level_t     request_level,
  input wire pgs_pkg::pgs_level_t     allowed_level,
  input wire logic                    attached,
  input wire logic                    vbus_enable,
  input wire logic                    vconn_enable,
  input wire logic                    supply_enable,
  input wire logic                    nine_volt_select,
  input wire logic                    twenty_volt_select,
  input wire logic [NUM_PROFILES-1:0] current_setting_select,
  input wire logic                    load_switch_enable
);
  import pgs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sel_excl_a: assert property (!(nine_volt_select && twenty_volt_select))
    else $error("both selects high");
  pwr_attach_a: assert property ($rose(vbus_enable) |-> $past(attached))
    else $error("power before attach");
  idle_low_a: assert property (!attached && !$past(attached) |-> !(vbus_enable
    || vconn_enable || supply_enable || load_switch_enable || |current_setting_select))
    else $error("output high while idle");
  start_5v_a: assert property ($rose(supply_enable) |->
    !nine_volt_select && !twenty_volt_select) else $error("supply not at 5V first");
  up_5v_a: assert property (role_source && supply_enable && !nine_volt_select
    && !twenty_volt_select && request_level == LVL_9V && allowed_level != LVL_5V
    |-> ##1 nine_volt_select) else $error("9V select late");
  swap_gap_a: assert property ($fell(nine_volt_select) && attached
    && request_level == LVL_20V && allowed_level == LVL_20V
    |-> ##[1:GAP_CYCLES] twenty_volt_select) else $error("20V select late");
  current_setting_select_load_a: assert property ($rose(|current_setting_select)
    |-> ##[1:GAP_CYCLES] ($rose(load_switch_enable) || !(|current_setting_select)))
    else $error("load enable late");
  load_current_setting_select_a: assert property (load_switch_enable |-> |current_setting_select)
    else $error("load without setting");
endmodule : pgs_sequencer_asserts

//--- test/pgs_port_partner.sv
// Far port: sink pull-down or source VBUS
`timescale 1ns/1ps
module pgs_port_partner (
  input  wire logic clk,
  input  wire logic plugged,
  input  wire logic far_is_sink,
  output logic      cc_rd_detect,
  output logic      vbus_detect
);
  initial begin
    cc_rd_detect = 1'b0;
    vbus_detect  = 1'b0;
  end
  always @(posedge clk) begin
    cc_rd_detect <= plugged && far_is_sink;
    vbus_detect  <= plugged && !far_is_sink;
  end
endmodule : pgs_port_partner

//--- test/pgs_sequencer_test.sv
// Self-checking bench for the power GPIO sequencer
`timescale 1ns/1ps
module pgs_sequencer_test;
  import pgs_pkg::*;
  localparam int GAP = 4;
  logic       clk = 1'b0, arst_n = 1'b0, role_source = 1'b1, plugged = 1'b0;
  logic       profile_valid = 1'b0;
  logic [1:0] profile_sel = 2'h0;
  pgs_level_t request_level = LVL_5V, allowed_level = LVL_5V;
  logic       cc_rd_detect, vbus_detect, attached, vbus_enable, vconn_enable;
  logic       supply_enable, nine_volt_select, twenty_volt_select, load_switch_enable;
  logic [3:0] current_setting_select;
  int         n_fail = 0, cmp_count = 0;
  always #50 clk = ~clk;
  pgs_sequencer #(.GAP_CYCLES(GAP)) dut (.*);
  pgs_port_partner u_far (.*, .far_is_sink(role_source));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Attach bit first; bit 0 is any current setting
  function automatic logic [7:0] outs();
    return {attached, vbus_enable, vconn_enable, supply_enable, nine_volt_select,
            twenty_volt_select, load_switch_enable, |current_setting_select};
  endfunction : outs
  task automatic wait_att();
    for (int i = 0; i < 8 && attached !== 1'b1; i++) cyc(1);
  endtask : wait_att
  task automatic test_reset();
    cyc(3);
    chk(outs(), 8'h00);
    arst_n = 1'b1;
    cyc(4);
    chk(outs(), 8'h00);
  endtask : test_reset
  task automatic test_source();
    request_level = LVL_9V;
    plugged = 1'b1;
    wait_att();
    chk(outs(), 8'h80);
    cyc(2);
    chk(outs(), 8'hF0);
    allowed_level = LVL_20V;
    cyc(2);
    chk(outs(), 8'hF8);
    request_level = LVL_20V;
    cyc(2);
    chk(outs(), 8'hF0);
    cyc(GAP);
    chk(outs(), 8'hF4);
    request_level = LVL_5V;
    cyc(2);
    chk(outs(), 8'hF0);
    plugged = 1'b0;
    cyc(6);
    chk(outs(), 8'h00);
  endtask : test_source
  task automatic test_sink();
    role_source = 1'b0;
    plugged = 1'b1;
    wait_att();
    for (int i = 0; i < 4; i++) begin
      profile_sel = 2'(i);
      profile_valid = 1'b1;
      cyc(2);
      chk(outs(), 8'h81);
      chk({4'h0, current_setting_select}, 8'h01 << i);
      cyc(GAP);
      chk(outs(), 8'h83);
      profile_valid = 1'b0;
      cyc(2);
    end
    plugged = 1'b0;
    cyc(6);
    chk(outs(), 8'h00);
  endtask : test_sink
  task automatic give_verdict();
    $display("Compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    test_reset();
    test_source();
    test_sink();
    give_verdict();
  end
  // Whole run is under a hundred cycles
  initial begin
    #100us;
    n_fail++;
    give_verdict();
  end
endmodule : pgs_sequencer_test
bind pgs_sequencer pgs_sequencer_asserts #(.NUM_PROFILES(NUM_PROFILES),
  .GAP_CYCLES(GAP_CYCLES)) u_chk (.*);
